// ---- dv/tb.sv ----
`timescale 1ns/1ns
`include "wcu_params.svh"
module tb;
    logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdv, rdo;
    logic signed [31:0] pos = 32'sh0, wp;
    logic awr, wrd, bv, arr, rv, pls, warn, alm, irq;
    logic [1:0] br, rr, rsp;
    logic [15:0] cnt;
    int err_count = 0, tests_run = 0, cyc = 0;
    int tr[7] = '{10, 45, 10000, 7, 10, 5, 10}, ga[7] = '{1, 1, 1, 1, 3, 1, 1}, gb[7];
    logic [31:0] rstv[8] = '{32'h1, 32'ha, 32'h1, 32'h1, 32'h1388, 32'h0, 32'h1, 32'h0};
    wcu_top DUT (.core_clk_i(clk), .rstn_i(rstn), .s_axi_awvalid_i(awv), .s_axi_awaddr_i(awa),
        .s_axi_awready_o(awr), .s_axi_wvalid_i(wv), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
        .s_axi_wready_o(wrd), .s_axi_bvalid_o(bv), .s_axi_bresp_o(br), .s_axi_bready_i(bry),
        .s_axi_arvalid_i(arv), .s_axi_araddr_i(ara), .s_axi_arready_o(arr), .s_axi_rvalid_o(rv),
        .s_axi_rdata_o(rdo), .s_axi_rresp_o(rr), .s_axi_rready_i(rry), .pos_i(pos),
        .wrapped_pos_o(wp), .division_boundary_pulse_o(pls), .wrap_warning_o(warn),
        .wrap_alarm_o(alm), .irq_o(irq));
    wcu_host_model u_host (.core_clk_i(clk), .rstn_i(rstn), .pulse_i(pls), .count_o(cnt));
    // Clock and hang guard
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            stop_test();
        end
    end
    task stop_test;
        $display("mismatches %0d compares %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Bus master: each channel released at its own handshake
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d; bry <= 1'b1;
        forever begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (bv) break;
        end
        rsp = br;
        bry <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge clk);
        arv <= 1'b1; ara <= a; rry <= 1'b1;
        forever begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        rdv = rdo; rsp = rr;
        rry <= 1'b0;
    endtask : rd
    // Waits out the recompute by polling the busy flag
    task idle;
        repeat (4) @(posedge clk);
        rd(8'h1c);
        while (rdv[3] !== 1'b0) rd(8'h1c);
    endtask : idle
    task cfg(input logic [7:0] a, input logic [31:0] d);
        wr(a, d);
        idle();
    endtask : cfg
    function automatic int fold(input int p, input int lo, input int l);
        int m;
        m = (p - lo) % l;
        if (m < 0) m += l;
        return lo + m;
    endfunction : fold
    function automatic int fl(input int p, input int s);
        return (p >= 0) ? p / s : -((s - 1 - p) / s);
    endfunction : fl
    function automatic logic ok(input int r, input int a, input int b);
        return (18000 % r == 0) && ((r * b * 100) % a == 0);
    endfunction : ok
    // Random walk with steps below the spacing, range of 1000 steps
    task walk(input int lo, input int sp, input logic en);
        int c0, e, np, st;
        @(posedge clk); pos <= 32'sh0;
        repeat (3) @(posedge clk);
        c0 = cnt; e = 0;
        for (int i = 0; i < 30; i++) begin
            st = $urandom_range(200) - 100;
            np = pos + st;
            if (np > 450 || np < -450) np = pos - st;
            if (en && fl(np, sp) != fl(pos, sp)) e++;
            @(posedge clk); pos <= np;
            repeat (2) @(posedge clk);
            chk(wp, en ? fold(np, lo, 1000) : np);
        end
        @(posedge clk);
        chk(cnt - c0, e);
    endtask : walk
    initial begin
        int l;
        void'($urandom(32'h8076e1b6));
        gb = '{1, 1, 1, 1, 1, 2, 1};
        gb[6] = $urandom_range(4, 1);
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        idle();
        for (int i = 0; i < 8; i++) begin
            rd((i == 7) ? 8'h24 : 8'(i * 4));
            chk(rdv, rstv[i]);
        end
        rd(8'h30);
        chk(rsp, `WCU_RESP_SLVERR);
        walk(-500, 1000, 1'b1);
        cfg(8'h18, 32'h4);
        walk(-500, 250, 1'b1);
        cfg(8'h10, 32'h0);
        cfg(8'h14, 32'hffffff9c);
        walk(-100, 250, 1'b1);
        cfg(8'h10, 32'h1388);
        cfg(8'h00, 32'h0);
        walk(0, 250, 1'b0);
        cfg(8'h00, 32'h1);
        wr(8'h24, 32'h1);
        cfg(8'h14, 32'h258);
        chk({warn, irq}, 2'b11);
        wr(8'h20, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        pos <= 32'sh2bc;
        cfg(8'h00, 32'h3);
        chk(alm, 1'b1);
        cfg(8'h14, 32'h0);
        cfg(8'h00, 32'h3);
        chk({alm, warn}, 2'b00);
        for (int i = 0; i < 7; i++) begin
            wr(8'h04, tr[i]);
            wr(8'h08, ga[i]);
            cfg(8'h0c, gb[i]);
            l = tr[i] * gb[i] * 100 / ga[i];
            chk(warn, !ok(tr[i], ga[i], gb[i]));
            chk(wp, ok(tr[i], ga[i], gb[i]) ? fold(700, -(l / 2), l) : 700);
        end
        stop_test();
    end
endmodule : tb

// ---- dv/wcu_host_model.sv ----
`timescale 1ns/1ns
// Host side: counts the boundary pulses it samples
module wcu_host_model (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Pulse in, running count out
    input wire logic pulse_i,
    output logic [15:0] count_o
);
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_o <= 16'h0000;
        end else if (pulse_i) begin
            count_o <= count_o + 16'h0001;
        end
    end
endmodule : wcu_host_model

// ---- dv/wcu_top_monitor.sv ----
`timescale 1ns/1ns
// Watches the top ports only
module wcu_top_monitor (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Bus
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rready_i,
    // Position
    input wire logic signed [31:0] pos_i,
    input wire logic signed [31:0] wrapped_pos_o,
    input wire logic division_boundary_pulse_o,
    input wire logic wrap_warning_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    a_bvalid_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
        s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bvalid dropped early");
    a_rvalid_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rvalid dropped early");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write answer late");
    a_write_blocked: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken during response");
    a_read_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken during response");
    // Slow catch-up after a recompute is not covered: the bench holds pos then
    a_pulse_moves: assert property (division_boundary_pulse_o |->
        $past(pos_i) != $past(pos_i, 2)) else $error("pulse without motion");
    a_warn_raw: assert property (wrap_warning_o && $past(wrap_warning_o, 2) |->
        wrapped_pos_o == $past(pos_i)) else $error("wrapping while warned");
endmodule : wcu_top_monitor
bind wcu_top wcu_top_monitor u_mon (.core_clk_i, .rstn_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bresp_o, .s_axi_bready_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rdata_o, .s_axi_rready_i,
    .pos_i, .wrapped_pos_o, .division_boundary_pulse_o, .wrap_warning_o);

// ---- hw/wcu_div_if.sv ----
`timescale 1ns/1ns
// Request and answer of the shared sequential divider
interface wcu_div_if;
    logic start;
    logic [63:0] dividend;
    logic [31:0] divisor;
    logic done;
    logic [63:0] quotient;
    logic [31:0] remainder;
    modport master (output start, output dividend, output divisor,
                    input done, input quotient, input remainder);
    modport slave (input start, input dividend, input divisor,
                   output done, output quotient, output remainder);
endinterface : wcu_div_if

// ---- hw/wcu_divider.sv ----
`timescale 1ns/1ns
// Restoring divider, one quotient bit per cycle; the unit only needs a
// handful of divisions per reconfiguration, so area beats speed here.
module wcu_divider
    import wcu_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Division port
    wcu_div_if.slave div
);

    wcu_div_s q;
    wcu_div_s d;
    logic [32:0] shifted;

    // Next state of the shift-subtract loop
    always_comb begin
        d = q;
        d.done = 1'b0;
        shifted = {q.rem[31:0], q.dvd[63]};
        if (!q.busy && div.start) begin
            d.busy = 1'b1;
            d.cnt = 7'h40;
            d.dvd = div.dividend;
            // A zero divisor would never finish sensibly, so it becomes one
            d.dvs = (div.divisor == 32'h0) ? 32'h1 : div.divisor;
            d.rem = 33'h0;
        end else if (q.busy) begin
            if (shifted >= {1'b0, q.dvs}) begin
                d.rem = shifted - {1'b0, q.dvs};
                d.dvd = {q.dvd[62:0], 1'b1};
            end else begin
                d.rem = shifted;
                d.dvd = {q.dvd[62:0], 1'b0};
            end
            d.cnt = q.cnt - 7'h1;
            if (q.cnt == 7'h1) begin
                d.busy = 1'b0;
                d.done = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign div.done = q.done;
    assign div.quotient = q.dvd;
    assign div.remainder = q.rem[31:0];

endmodule : wcu_divider

// ---- hw/wcu_params.svh ----
`ifndef WCU_PARAMS_SVH
`define WCU_PARAMS_SVH

// ***************************************************************
// Register byte offsets
// ***************************************************************
`define WCU_OFF_CTRL 8'h00
`define WCU_OFF_RANGE 8'h04
`define WCU_OFF_GEAR_A 8'h08
`define WCU_OFF_GEAR_B 8'h0c
`define WCU_OFF_RATIO 8'h10
`define WCU_OFF_OFFSET 8'h14
`define WCU_OFF_NDIV 8'h18
`define WCU_OFF_STATUS 8'h1c
`define WCU_OFF_IRQ_ST 8'h20
`define WCU_OFF_IRQ_MASK 8'h24
`define WCU_OFF_WPOS 8'h28
`define WCU_OFF_SPACING 8'h2c

// ***************************************************************
// Field positions
// ***************************************************************
`define WCU_CTRL_EN_BIT 0
`define WCU_CTRL_CFG_BIT 1
`define WCU_ST_WARN_BIT 0
`define WCU_ST_ALARM_BIT 1
`define WCU_ST_ACTIVE_BIT 2
`define WCU_ST_BUSY_BIT 3
`define WCU_IRQ_WARN_BIT 0
`define WCU_IRQ_ALARM_BIT 1
`define WCU_IRQ_PULSE_BIT 2

// ***************************************************************
// Reset values and limits
// ***************************************************************
`define WCU_RST_EN 1'b1
`define WCU_RST_RANGE 32'h0000000a
`define WCU_RST_GEAR 32'h00000001
`define WCU_RST_RATIO 32'h00001388
`define WCU_RST_OFFSET 32'h00000000
`define WCU_RST_NDIV 32'h00000001
`define WCU_FULL_TENTHS 32'h00004650
`define WCU_STEP_SCALE 64'h0000000000000064
`define WCU_RATIO_FULL 32'h00002710
`define WCU_NDIV_MAX 32'h1fffffff
`define WCU_OFFSET_MIN (-48'sd536870912)
`define WCU_OFFSET_MAX 48'sd536870911
`define WCU_LEN_MAX 48'sh00007fffffff
`define WCU_RESP_OKAY 2'b00
`define WCU_RESP_SLVERR 2'b10

`endif

// ---- hw/wcu_pkg.sv ----
package wcu_pkg;

    // Recompute sequence, one state per division
    typedef enum logic [2:0] {
        WCU_S_IDLE = 3'b000,
        WCU_S_FULL = 3'b001,
        WCU_S_LEN = 3'b010,
        WCU_S_LOW = 3'b011,
        WCU_S_SPC = 3'b100,
        WCU_S_WPOS = 3'b101,
        WCU_S_PHASE = 3'b110
    } wcu_seq_e;

    // Divider state
    typedef struct packed {
        logic busy;
        logic done;
        logic [6:0] cnt;
        logic [63:0] dvd;
        logic [31:0] dvs;
        logic [32:0] rem;
    } wcu_div_s;

    // Top-level state
    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic wrap_en;
        logic [31:0] range;
        logic [31:0] gear_a;
        logic [31:0] gear_b;
        logic [31:0] ratio;
        logic [31:0] offs;
        logic [31:0] ndiv;
        logic [2:0] irq_st;
        logic [2:0] irq_mask;
        logic irq;
        wcu_seq_e seq;
        logic pend;
        logic esc_pend;
        logic esc;
        logic c1_ok;
        logic c2_ok;
        logic neg;
        logic div_start;
        logic [63:0] div_dvd;
        logic [31:0] div_dvs;
        logic signed [47:0] len;
        logic signed [47:0] lower;
        logic signed [47:0] spacing;
        logic signed [31:0] pos_snap;
        logic signed [31:0] pos_prev;
        logic signed [47:0] wpos;
        logic signed [47:0] phase;
        logic active;
        logic warn;
        logic alarm;
        logic pulse;
    } wcu_state_s;

endpackage : wcu_pkg

// ---- hw/wcu_top.sv ----
// Overview of operation
// - Range valid only if 1800 rev divided by the range is whole.
// - Range times gear B over gear A times 1000 must be whole steps.
// - Enabled with a failed check gives a warning and no wrapping.
// - Warning at power-up or configuration step escalates to an alarm.
// - Range boundary placed from home, shifted negative by the ratio.
// - Ratio-shifted coordinates further moved by the step offset.
// - Step offset leaving home outside the range gives the warning.
// - Boundary pulse at each equal division point, counted from home.
// - Division count setting 1 to 536870911, reset value 1.
// - Boundary pulse only while wrapping is enabled.
// - Command position returns to zero every wrap range, 0.1 rev units.
// - Offset ratio 0 to 10000 in 0.01 percent, reset value 5000.
// - Signed step offset -536870912 to 536870911, reset value zero.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "wcu_params.svh"
module wcu_top
    import wcu_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // AXI4-Lite write channels
    input wire logic s_axi_awvalid_i,
    input wire logic [7:0] s_axi_awaddr_i,
    output logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    output logic s_axi_wready_o,
    output logic s_axi_bvalid_o,
    output logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read channels
    input wire logic s_axi_arvalid_i,
    input wire logic [7:0] s_axi_araddr_i,
    output logic s_axi_arready_o,
    output logic s_axi_rvalid_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rready_i,
    // Position counter
    input wire logic signed [31:0] pos_i,
    // Results
    output logic signed [31:0] wrapped_pos_o,
    output logic division_boundary_pulse_o,
    output logic wrap_warning_o,
    output logic wrap_alarm_o,
    output logic irq_o
);

    wcu_state_s q;
    wcu_state_s d;
    wcu_div_if div_bus ();

    // ***************************************************************
    // Helper functions
    // ***************************************************************

    // Byte-lane merge of a register write
    function automatic logic [31:0] wcu_merge(input logic [31:0] old, input logic [31:0] val,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return res;
    endfunction : wcu_merge

    // Known register offset
    function automatic logic wcu_mapped(input logic [7:0] addr);
        return (addr[1:0] == 2'b00) && (addr <= `WCU_OFF_SPACING);
    endfunction : wcu_mapped

    // Magnitude of a signed value for the unsigned divider
    function automatic logic [63:0] wcu_abs(input logic signed [47:0] v);
        logic signed [47:0] m;
        m = (v < 0) ? -v : v;
        return {16'h0, m};
    endfunction : wcu_abs

    // ***************************************************************
    // Shared divider
    // ***************************************************************
    assign div_bus.start = q.div_start;
    assign div_bus.dividend = q.div_dvd;
    assign div_bus.divisor = q.div_dvs;

    wcu_divider u_div (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .div(div_bus.slave)
    );

    // ***************************************************************
    // Next state
    // ***************************************************************
    logic signed [47:0] delta;
    logic signed [47:0] w_next;
    logic signed [47:0] p_next;
    logic signed [47:0] upper;
    logic signed [47:0] rem_s;
    logic signed [47:0] quot_s;
    logic bad;
    logic [2:0] ev;
    logic wr_fire;

    always_comb begin
        d = q;
        d.div_start = 1'b0;
        d.pulse = 1'b0;
        ev = 3'b000;
        delta = 48'(pos_i - q.pos_prev);
        w_next = q.wpos + delta;
        p_next = q.phase + delta;
        upper = q.lower + q.len - 48'sd1;
        rem_s = {16'h0, div_bus.remainder};
        quot_s = div_bus.quotient[47:0];
        bad = 1'b0;
        wr_fire = q.aw_got && q.w_got && !q.bvalid;

        // Write address and data are caught separately, in either order
        if (s_axi_awvalid_i && q.awready) begin
            d.aw_got = 1'b1;
            d.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && q.wready) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata_i;
            d.wstrb = s_axi_wstrb_i;
        end
        if (wr_fire) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = wcu_mapped(q.aw_addr) ? `WCU_RESP_OKAY : `WCU_RESP_SLVERR;
            unique case (q.aw_addr)
                `WCU_OFF_CTRL: begin
                    if (q.wstrb[0]) begin
                        d.wrap_en = q.wdata[`WCU_CTRL_EN_BIT];
                        d.pend = 1'b1;
                        if (q.wdata[`WCU_CTRL_CFG_BIT]) begin
                            d.esc_pend = 1'b1;
                        end
                    end
                end
                `WCU_OFF_RANGE: d.range = wcu_merge(q.range, q.wdata, q.wstrb);
                `WCU_OFF_GEAR_A: d.gear_a = wcu_merge(q.gear_a, q.wdata, q.wstrb);
                `WCU_OFF_GEAR_B: d.gear_b = wcu_merge(q.gear_b, q.wdata, q.wstrb);
                `WCU_OFF_RATIO: d.ratio = wcu_merge(q.ratio, q.wdata, q.wstrb);
                `WCU_OFF_OFFSET: d.offs = wcu_merge(q.offs, q.wdata, q.wstrb);
                `WCU_OFF_NDIV: d.ndiv = wcu_merge(q.ndiv, q.wdata, q.wstrb);
                `WCU_OFF_IRQ_ST: d.irq_st = q.irq_st & ~q.wdata[2:0];
                `WCU_OFF_IRQ_MASK: d.irq_mask = q.wdata[2:0];
                default: ;
            endcase
            // Any setting change re-evaluates the range
            if (q.aw_addr >= `WCU_OFF_RANGE && q.aw_addr <= `WCU_OFF_NDIV) begin
                d.pend = 1'b1;
            end
        end
        if (q.bvalid && s_axi_bready_i) begin
            d.bvalid = 1'b0;
        end
        d.awready = !d.aw_got && !d.bvalid;
        d.wready = !d.w_got && !d.bvalid;

        // Read answer one cycle after the address is taken
        if (s_axi_arvalid_i && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp = wcu_mapped(s_axi_araddr_i) ? `WCU_RESP_OKAY : `WCU_RESP_SLVERR;
            unique case (s_axi_araddr_i)
                `WCU_OFF_CTRL: d.rdata = {31'h0, q.wrap_en};
                `WCU_OFF_RANGE: d.rdata = q.range;
                `WCU_OFF_GEAR_A: d.rdata = q.gear_a;
                `WCU_OFF_GEAR_B: d.rdata = q.gear_b;
                `WCU_OFF_RATIO: d.rdata = q.ratio;
                `WCU_OFF_OFFSET: d.rdata = q.offs;
                `WCU_OFF_NDIV: d.rdata = q.ndiv;
                `WCU_OFF_STATUS: d.rdata = {28'h0, (q.seq != WCU_S_IDLE) || q.pend, q.active,
                                            q.alarm, q.warn};
                `WCU_OFF_IRQ_ST: d.rdata = {29'h0, q.irq_st};
                `WCU_OFF_IRQ_MASK: d.rdata = {29'h0, q.irq_mask};
                `WCU_OFF_WPOS: d.rdata = q.wpos[31:0];
                `WCU_OFF_SPACING: d.rdata = q.spacing[31:0];
                default: d.rdata = 32'h0;
            endcase
        end else if (q.rvalid && s_axi_rready_i) begin
            d.rvalid = 1'b0;
        end
        d.arready = !d.rvalid;

        // Recompute sequence: one division per state
        unique case (q.seq)
            WCU_S_IDLE: begin
                if (q.pend) begin
                    d.pend = 1'b0;
                    d.esc = q.esc_pend;
                    d.esc_pend = 1'b0;
                    d.active = 1'b0;
                    // full coordinate span over the range
                    d.div_dvd = {32'h0, `WCU_FULL_TENTHS};
                    d.div_dvs = q.range;
                    d.div_start = 1'b1;
                    d.seq = WCU_S_FULL;
                end
            end
            WCU_S_FULL: begin
                if (div_bus.done) begin
                    d.c1_ok = (div_bus.remainder == 32'h0) && (q.range != 32'h0);
                    // range in tenths times gear B times 100 over gear A
                    d.div_dvd = {32'h0, q.range} * {32'h0, q.gear_b} * `WCU_STEP_SCALE;
                    d.div_dvs = q.gear_a;
                    d.div_start = 1'b1;
                    d.seq = WCU_S_LEN;
                end
            end
            WCU_S_LEN: begin
                if (div_bus.done) begin
                    d.c2_ok = (div_bus.remainder == 32'h0) && (q.gear_a != 32'h0);
                    d.len = quot_s;
                    d.div_dvd = 64'(quot_s[31:0] * q.ratio);
                    d.div_dvs = `WCU_RATIO_FULL;
                    d.div_start = 1'b1;
                    d.seq = WCU_S_LOW;
                end
            end
            WCU_S_LOW: begin
                if (div_bus.done) begin
                    d.lower = 48'($signed(q.offs)) - quot_s;
                    d.div_dvd = {16'h0, q.len};
                    d.div_dvs = q.ndiv;
                    d.div_start = 1'b1;
                    d.seq = WCU_S_SPC;
                end
            end
            WCU_S_SPC: begin
                if (div_bus.done) begin
                    d.spacing = (quot_s == 48'sh0) ? 48'sh1 : quot_s;
                    d.pos_snap = pos_i;
                    d.neg = (48'(pos_i) - q.lower) < 0;
                    d.div_dvd = wcu_abs(48'(pos_i) - q.lower);
                    d.div_dvs = q.len[31:0];
                    d.div_start = 1'b1;
                    d.seq = WCU_S_WPOS;
                end
            end
            WCU_S_WPOS: begin
                if (div_bus.done) begin
                    // folded start parked in phase until the verdict is known
                    d.phase = q.lower + ((q.neg && rem_s != 0) ? q.len - rem_s : rem_s);
                    d.neg = q.pos_snap < 0;
                    d.div_dvd = wcu_abs(48'(q.pos_snap));
                    d.div_dvs = q.spacing[31:0];
                    d.div_start = 1'b1;
                    d.seq = WCU_S_PHASE;
                end
            end
            WCU_S_PHASE: begin
                if (div_bus.done) begin
                    d.wpos = q.phase;
                    d.phase = (q.neg && rem_s != 0) ? q.spacing - rem_s : rem_s;
                    d.pos_prev = q.pos_snap;
                    // settings outside their ranges are invalid
                    bad = (q.ratio > `WCU_RATIO_FULL) || (q.ndiv == 32'h0)
                        || (q.ndiv > `WCU_NDIV_MAX) || (q.len <= 0)
                        || (q.len > `WCU_LEN_MAX)
                        || ($signed(48'($signed(q.offs))) < `WCU_OFFSET_MIN)
                        || ($signed(48'($signed(q.offs))) > `WCU_OFFSET_MAX);
                    // home must lie inside the wrapped range
                    bad = bad || (q.lower > 0) || (upper < 0);
                    // failed check on an enabled wrap warns
                    d.warn = q.wrap_en && (bad || !q.c1_ok || !q.c2_ok);
                    d.active = q.wrap_en && !d.warn;
                    // escalate at power-up or configuration step
                    if (q.esc) begin
                        d.alarm = d.warn;
                    end
                    ev[`WCU_IRQ_WARN_BIT] = d.warn && !q.warn;
                    ev[`WCU_IRQ_ALARM_BIT] = d.alarm && !q.alarm;
                    d.seq = WCU_S_IDLE;
                end
            end
            default: d.seq = WCU_S_IDLE;
        endcase

        // Folding assumes a step per cycle below one range, boundary tracking below one spacing
        if (q.active && q.seq == WCU_S_IDLE) begin
            d.pos_prev = pos_i;
            if (w_next > upper) begin
                d.wpos = w_next - q.len;
            end else if (w_next < q.lower) begin
                d.wpos = w_next + q.len;
            end else begin
                d.wpos = w_next;
            end
            // one pulse per crossing, only while enabled
            if (p_next >= q.spacing) begin
                d.phase = p_next - q.spacing;
                d.pulse = 1'b1;
            end else if (p_next < 0) begin
                d.phase = p_next + q.spacing;
                d.pulse = 1'b1;
            end else begin
                d.phase = p_next;
            end
        end else if (!d.active) begin
            // no wrapping, the raw position passes through
            d.wpos = 48'(pos_i);
        end
        ev[`WCU_IRQ_PULSE_BIT] = d.pulse;

        // Sticky status; a new event wins over a clear in the same cycle
        d.irq_st = d.irq_st | ev;
        d.irq = |(d.irq_st & d.irq_mask);
    end

    // ***************************************************************
    // State register
    // ***************************************************************
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
            q.wrap_en <= `WCU_RST_EN;
            q.range <= `WCU_RST_RANGE;
            q.gear_a <= `WCU_RST_GEAR;
            q.gear_b <= `WCU_RST_GEAR;
            q.ratio <= `WCU_RST_RATIO;
            q.offs <= `WCU_RST_OFFSET;
            q.ndiv <= `WCU_RST_NDIV;
            q.seq <= WCU_S_IDLE;
            // Power-up evaluation counts as reapplied control power
            q.pend <= 1'b1;
            q.esc_pend <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready_o = q.awready;
    assign s_axi_wready_o = q.wready;
    assign s_axi_bvalid_o = q.bvalid;
    assign s_axi_bresp_o = q.bresp;
    assign s_axi_arready_o = q.arready;
    assign s_axi_rvalid_o = q.rvalid;
    assign s_axi_rdata_o = q.rdata;
    assign s_axi_rresp_o = q.rresp;
    assign wrapped_pos_o = q.wpos[31:0];
    assign division_boundary_pulse_o = q.pulse;
    assign wrap_warning_o = q.warn;
    assign wrap_alarm_o = q.alarm;
    assign irq_o = q.irq;

endmodule : wcu_top
